/* File: design/agp_bridge_pkg.sv */
// Package for the bridge ISA-alias filter and error control block.
// Assumes one 200 MHz clock and a 32-bit AHB-Lite register bus.
package agp_bridge_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_ERROR_COMMAND  = 8'h40;
	localparam logic [7:0] ADDR_BRIDGE_CONTROL = 8'h44;
	localparam logic [7:0] ADDR_IO_WINDOW      = 8'h48;
	localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h4C;
	localparam logic [7:0] ADDR_IRQ_MASK       = 8'h50;

	// Error command fields
	localparam int          ERRCMD_TABORT_BIT = 0;
	localparam logic [7:0]  ERRCMD_RESET      = 8'h00;
	localparam logic [7:0]  ERRCMD_WR_MASK    = 8'h01;

	// Bridge control fields
	localparam int BCTL_PARITY_RESP_BIT = 0;
	localparam int BCTL_SERR_FWD_BIT    = 1;
	localparam int BCTL_ISA_FILTER_BIT  = 2;
	localparam int BCTL_SERRE_BIT       = 8;
	localparam logic [8:0] BCTL_RESET   = 9'h000;
	localparam logic [8:0] BCTL_WR_MASK = 9'h107;

	// I/O window fields
	localparam int IO_ADDR_W         = 16;
	localparam int IOWIN_LIMIT_LSB   = 16;
	localparam logic [15:0] IO_BASE_RESET  = 16'hFFFF;
	localparam logic [15:0] IO_LIMIT_RESET = 16'h0000;

	// ISA alias: bits 9:8 nonzero select the upper 768 bytes of a 1KB block
	localparam int ISA_ALIAS_MSB = 9;
	localparam int ISA_ALIAS_LSB = 8;

	// Interrupt status bits
	localparam int IRQ_W             = 4;
	localparam int IRQ_PARITY_BIT    = 0;
	localparam int IRQ_TABORT_BIT    = 1;
	localparam int IRQ_SERR_BIT      = 2;
	localparam int IRQ_ISA_BIT       = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;

	typedef struct packed {
		logic                 valid;
		logic [IO_ADDR_W-1:0] addr;
	} io_req_t;

	typedef struct packed {
		logic valid;
		logic to_secondary;
		logic to_hub;
	} io_route_t;

	typedef struct packed {
		logic parity;
		logic tabort;
		logic other;
	} err_evt_t;

endpackage

/* File: design/agp_bridge_isa_io_and_error_control.sv */
// ISA-alias I/O routing, secondary parity and target-abort error reporting,
// with an AHB-Lite register slave and a level interrupt.
// Assumes request and error inputs come from logic on hclk.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module agp_bridge_isa_io_and_error_control
	import agp_bridge_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	input  wire io_req_t     io_req,
	output io_route_t        io_route,
	input  wire err_evt_t    err_evt,
	output logic             serr_cycle,
	output logic             irq
);

	typedef struct packed {
		logic                 hreadyout;
		logic [31:0]          hrdata;
		logic                 pend_write;
		logic                 pend_read;
		logic [7:0]           pend_addr;
		logic [7:0]           err_cmd;
		logic [8:0]           bctl;
		logic [15:0]          io_base;
		logic [15:0]          io_limit;
		logic [IRQ_W-1:0]     irq_status;
		logic [IRQ_W-1:0]     irq_mask;
		logic                 irq;
		io_route_t            route;
		logic                 serr;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic                 in_window;
	logic                 isa_alias;
	logic                 filtered;
	logic                 parity_report;
	logic                 other_report;
	logic                 tabort_report;
	logic                 addr_phase;
	logic [IRQ_W-1:0]     irq_set;
	logic [IRQ_W-1:0]     irq_clr;
	logic [31:0]          rd_value;

	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

	// Window compare and ISA alias detection
	assign in_window = (io_req.addr >= state_reg.io_base) && (io_req.addr <= state_reg.io_limit);
	assign isa_alias = (io_req.addr[ISA_ALIAS_MSB:ISA_ALIAS_LSB] != 2'h0);
	assign filtered  = in_window && state_reg.bctl[BCTL_ISA_FILTER_BIT] && isa_alias;

	// Error reporting terms; forward bit deliberately unused
	assign parity_report = err_evt.parity && state_reg.bctl[BCTL_PARITY_RESP_BIT]
		&& state_reg.bctl[BCTL_SERRE_BIT];
	assign other_report  = err_evt.other && state_reg.bctl[BCTL_SERRE_BIT];
	assign tabort_report = err_evt.tabort && state_reg.err_cmd[ERRCMD_TABORT_BIT];

	always_comb begin
		rd_value = 32'h0000_0000;
		case (state_reg.pend_addr)
			ADDR_ERROR_COMMAND: begin
				rd_value[7:0] = state_reg.err_cmd;
			end
			ADDR_BRIDGE_CONTROL: begin
				rd_value[8:0] = state_reg.bctl;
			end
			ADDR_IO_WINDOW: begin
				rd_value = {state_reg.io_limit, state_reg.io_base};
			end
			ADDR_IRQ_STATUS: begin
				rd_value[IRQ_W-1:0] = state_reg.irq_status;
			end
			ADDR_IRQ_MASK: begin
				rd_value[IRQ_W-1:0] = state_reg.irq_mask;
			end
			default: begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		irq_set    = IRQ_RESET;
		irq_clr    = IRQ_RESET;

		// Bus slave: writes land in the data phase, reads take one wait state
		state_next.hreadyout  = 1'b1;
		state_next.pend_write = 1'b0;
		if (state_reg.pend_write) begin
			case (state_reg.pend_addr)
				ADDR_ERROR_COMMAND: begin
					state_next.err_cmd = hwdata[7:0] & ERRCMD_WR_MASK;
				end
				ADDR_BRIDGE_CONTROL: begin
					state_next.bctl = hwdata[8:0] & BCTL_WR_MASK;
				end
				ADDR_IO_WINDOW: begin
					state_next.io_base  = hwdata[IO_ADDR_W-1:0];
					state_next.io_limit = hwdata[IOWIN_LIMIT_LSB+IO_ADDR_W-1:IOWIN_LIMIT_LSB];
				end
				ADDR_IRQ_STATUS: begin
					irq_clr = hwdata[IRQ_W-1:0];
				end
				ADDR_IRQ_MASK: begin
					state_next.irq_mask = hwdata[IRQ_W-1:0];
				end
				default: begin
					state_next.pend_write = 1'b0;
				end
			endcase
		end
		if (state_reg.pend_read) begin
			state_next.hrdata    = rd_value;
			state_next.pend_read = 1'b0;
		end
		if (addr_phase) begin
			state_next.pend_addr  = haddr[7:0] & ((haddr[31:8] == 24'h000000) ? 8'hFF : 8'h00);
			state_next.pend_write = hwrite;
			state_next.pend_read  = !hwrite;
			state_next.hreadyout  = hwrite;
		end

		// I/O routing, one cycle after the request
		state_next.route.valid        = io_req.valid;
		state_next.route.to_secondary = io_req.valid && in_window && !filtered;
		state_next.route.to_hub       = io_req.valid && (!in_window || filtered);

		// SERR special cycle request
		state_next.serr = parity_report || other_report || tabort_report;

		// Sticky events: set wins over a same-cycle clear
		irq_set[IRQ_PARITY_BIT] = err_evt.parity;
		irq_set[IRQ_TABORT_BIT] = err_evt.tabort;
		irq_set[IRQ_SERR_BIT]   = state_next.serr;
		irq_set[IRQ_ISA_BIT]    = io_req.valid && filtered;
		state_next.irq_status   = (state_reg.irq_status & ~irq_clr) | irq_set;
		state_next.irq          = |(state_next.irq_status & state_next.irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg.hreadyout  <= 1'b1;
			state_reg.hrdata     <= 32'h0000_0000;
			state_reg.pend_write <= 1'b0;
			state_reg.pend_read  <= 1'b0;
			state_reg.pend_addr  <= 8'h00;
			state_reg.err_cmd    <= ERRCMD_RESET;
			state_reg.bctl       <= BCTL_RESET;
			state_reg.io_base    <= IO_BASE_RESET;
			state_reg.io_limit   <= IO_LIMIT_RESET;
			state_reg.irq_status <= IRQ_RESET;
			state_reg.irq_mask   <= IRQ_RESET;
			state_reg.irq        <= 1'b0;
			state_reg.route      <= '0;
			state_reg.serr       <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign hrdata     = state_reg.hrdata;
	assign hreadyout  = state_reg.hreadyout;
	assign hresp      = HRESP_OKAY;
	assign io_route   = state_reg.route;
	assign serr_cycle = state_reg.serr;
	assign irq        = state_reg.irq;

	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_outside_req;
		io_req.valid && !in_window;
	endsequence

	sequence s_alias_req;
		io_req.valid && in_window && isa_alias && state_reg.bctl[BCTL_ISA_FILTER_BIT];
	endsequence

	sequence s_parity_enabled;
		err_evt.parity && state_reg.bctl[BCTL_PARITY_RESP_BIT] && state_reg.bctl[BCTL_SERRE_BIT];
	endsequence

	sequence s_serr_then_sticky;
		serr_cycle && state_reg.irq_status[IRQ_SERR_BIT];
	endsequence

	sequence s_read_phase;
		addr_phase && !hwrite;
	endsequence

	sequence s_write_phase;
		addr_phase && hwrite;
	endsequence

	sequence s_status_kept;
		!(state_reg.pend_write && state_reg.pend_addr == ADDR_IRQ_STATUS);
	endsequence

	a_window_only: assert property (s_outside_req |=> io_route.valid && io_route.to_hub
		&& !io_route.to_secondary)
		else $error("Access outside window not routed to hub");

	a_isa_block: assert property (s_alias_req |=> io_route.valid && !io_route.to_secondary)
		else $error("ISA alias access forwarded to secondary bus");

	a_isa_to_hub: assert property (s_alias_req |=> io_route.to_hub)
		else $error("Filtered ISA alias access not sent to hub");

	a_plain_pass: assert property (io_req.valid && in_window && !isa_alias |=> io_route.to_secondary)
		else $error("Window access without alias not forwarded");

	a_no_spurious: assert property (!err_evt.parity && !err_evt.tabort && !err_evt.other |=> !serr_cycle)
		else $error("SERR raised with no error event");

	a_parity_report: assert property (s_parity_enabled |=> s_serr_then_sticky)
		else $error("Enabled parity error not reported");

	a_parity_quiet: assert property (err_evt.parity && !state_reg.bctl[BCTL_PARITY_RESP_BIT]
		&& !err_evt.tabort && !err_evt.other |=> !serr_cycle)
		else $error("Parity error reported while response disabled");

	a_other_report: assert property (err_evt.other && state_reg.bctl[BCTL_SERRE_BIT] |=> serr_cycle)
		else $error("Other error not reported");

	a_tabort_report: assert property (err_evt.tabort && state_reg.err_cmd[ERRCMD_TABORT_BIT]
		|=> serr_cycle && state_reg.irq_status[IRQ_TABORT_BIT])
		else $error("Target abort not reported");

	a_tabort_quiet: assert property (err_evt.tabort && !state_reg.err_cmd[ERRCMD_TABORT_BIT]
		&& !err_evt.parity && !err_evt.other |=> !serr_cycle)
		else $error("Target abort reported while disabled");

	a_read_wait: assert property (s_read_phase |=> !hreadyout ##1 hreadyout)
		else $error("Read did not take exactly one wait state");

	a_irq_level: assert property (irq == |(state_reg.irq_status & state_reg.irq_mask))
		else $error("Interrupt output does not follow masked status");

	a_write_no_wait: assert property (s_write_phase |=> hreadyout)
		else $error("Write inserted a wait state");

	a_route_onehot: assert property (io_route.valid |-> io_route.to_secondary != io_route.to_hub)
		else $error("Routed access has no single destination");

	a_route_idle: assert property (!io_route.valid |-> !io_route.to_secondary && !io_route.to_hub)
		else $error("Destination flag without routed access");

	a_route_follows: assert property (!io_req.valid |=> !io_route.valid)
		else $error("Routed access with no request");

	a_filter_off: assert property (io_req.valid && in_window && !state_reg.bctl[BCTL_ISA_FILTER_BIT]
		|=> io_route.to_secondary)
		else $error("Window access not forwarded with filter off");

	a_isa_status: assert property (s_alias_req |=> state_reg.irq_status[IRQ_ISA_BIT])
		else $error("Filtered access not flagged");

	a_parity_no_enable: assert property (err_evt.parity && !state_reg.bctl[BCTL_SERRE_BIT]
		&& !err_evt.tabort && !err_evt.other |=> !serr_cycle)
		else $error("Parity error reported without report enable");

	a_forward_inert: assert property (err_evt.parity && state_reg.bctl[BCTL_SERR_FWD_BIT]
		&& !state_reg.bctl[BCTL_PARITY_RESP_BIT] && !err_evt.tabort && !err_evt.other |=> !serr_cycle)
		else $error("Forward bit changed parity reporting");

	a_other_any_resp: assert property (err_evt.other && state_reg.bctl[BCTL_SERRE_BIT]
		&& !state_reg.bctl[BCTL_PARITY_RESP_BIT] |=> serr_cycle)
		else $error("Other error dropped with parity response clear");

	a_other_quiet: assert property (err_evt.other && !state_reg.bctl[BCTL_SERRE_BIT]
		&& !err_evt.parity && !err_evt.tabort |=> !serr_cycle)
		else $error("Other error reported without report enable");

	a_tabort_ungated: assert property (err_evt.tabort && state_reg.err_cmd[ERRCMD_TABORT_BIT]
		&& !state_reg.bctl[BCTL_SERRE_BIT] |=> serr_cycle)
		else $error("Target abort report depends on report enable");

	a_parity_sticky: assert property (err_evt.parity |=> state_reg.irq_status[IRQ_PARITY_BIT])
		else $error("Parity event not flagged");

	a_tabort_sticky: assert property (err_evt.tabort |=> state_reg.irq_status[IRQ_TABORT_BIT])
		else $error("Target abort event not flagged");

	a_serr_cause: assert property (serr_cycle |-> $past(err_evt.parity) || $past(err_evt.tabort)
		|| $past(err_evt.other))
		else $error("SERR cycle without a preceding error event");

	a_status_hold: assert property (s_status_kept |=> (state_reg.irq_status & $past(state_reg.irq_status))
		== $past(state_reg.irq_status))
		else $error("Sticky status bit dropped without a clear");

	a_cmd_reserved: assert property ((state_reg.err_cmd & ~ERRCMD_WR_MASK) == 8'h00)
		else $error("Reserved error command bit set");

	a_bctl_reserved: assert property ((state_reg.bctl & ~BCTL_WR_MASK) == 9'h000)
		else $error("Reserved bridge control bit set");

	// Read data matches the register seen in the wait state
	a_read_command: assert property (state_reg.pend_read && state_reg.pend_addr == ADDR_ERROR_COMMAND
		|=> hrdata == {24'h000000, $past(state_reg.err_cmd)})
		else $error("Error command read returned wrong data");

	a_read_bctl: assert property (state_reg.pend_read && state_reg.pend_addr == ADDR_BRIDGE_CONTROL
		|=> hrdata == {23'h000000, $past(state_reg.bctl)})
		else $error("Bridge control read returned wrong data");

	a_read_window: assert property (state_reg.pend_read && state_reg.pend_addr == ADDR_IO_WINDOW
		|=> hrdata == {$past(state_reg.io_limit), $past(state_reg.io_base)})
		else $error("Window read returned wrong data");

	a_read_status: assert property (state_reg.pend_read && state_reg.pend_addr == ADDR_IRQ_STATUS
		|=> hrdata == {28'h0000000, $past(state_reg.irq_status)})
		else $error("Status read returned wrong data");

	a_read_mask: assert property (state_reg.pend_read && state_reg.pend_addr == ADDR_IRQ_MASK
		|=> hrdata == {28'h0000000, $past(state_reg.irq_mask)})
		else $error("Mask read returned wrong data");

endmodule

/* File: testbench/secondary_bus_model.sv */
// Model of the secondary bus devices: counts I/O cycles forwarded to them and raises error events.
// Assumes it shares hclk and hresetn with the bridge; the bench commands each fault.
`timescale 1ns/1ps
module secondary_bus_model
	import agp_bridge_pkg::*;
(
	input  wire logic      hclk,
	input  wire logic      hresetn,
	input  wire io_route_t io_route,
	input  wire err_evt_t  fault,
	output err_evt_t       err_evt,
	output logic [7:0]     sec_count
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_evt   <= '0;
			sec_count <= 8'h00;
		end else begin
			err_evt <= fault;
			if (io_route.valid && io_route.to_secondary)
				sec_count <= sec_count + 8'h01;
		end
	end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the ISA-alias filter and error control block.
// Assumes the design package and the secondary bus model are compiled first.
`timescale 1ns/1ps
module tb;
	import agp_bridge_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy, irq, serr_cycle, hreadyout;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rdq, q;
	logic [1:0]  htrans = 0, hresp;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  sec_count;
	io_req_t     io_req = '0;
	io_route_t   io_route;
	err_evt_t    fault = '0, err_evt;
	int          miscompares = 0, checks = 0, cycles = 0;

	agp_bridge_isa_io_and_error_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .io_req(io_req), .io_route(io_route), .err_evt(err_evt),
		.serr_cycle(serr_cycle), .irq(irq));
	secondary_bus_model far (.hclk(hclk), .hresetn(hresetn), .io_route(io_route), .fault(fault),
		.err_evt(err_evt), .sec_count(sec_count));

	always #2.5 hclk = ~hclk;
	// Values as seen by the next rising edge
	always @(negedge hclk) begin
		rdy = hreadyout;
		rdq = hrdata;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= w;
		do @(posedge hclk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (rdy !== 1'b1);
		q = rdq;
		check("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
	endtask
	task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check(name, q, exp);
	endtask
	task automatic io(input logic [15:0] a, input logic hub);
		@(posedge hclk);
		io_req <= '{valid: 1'b1, addr: a};
		@(posedge hclk);
		io_req <= '0;
		#1;
		check("io_route", {29'h0, io_route}, {29'h0, 1'b1, !hub, hub});
		@(posedge hclk);
		#1;
		check("io_route end", {29'h0, io_route}, 32'h0);
	endtask
	task automatic err(input err_evt_t e, input logic exp);
		@(posedge hclk);
		fault <= e;
		@(posedge hclk);
		fault <= '0;
		@(posedge hclk);
		#1;
		check("serr_cycle", {31'h0, serr_cycle}, {31'h0, exp});
		@(posedge hclk);
		#1;
		check("serr_cycle end", {31'h0, serr_cycle}, 32'h0);
	endtask

	task automatic test_reset;
		rd("error_command", {24'h0, ADDR_ERROR_COMMAND}, 32'h0);
		rd("bridge_control", {24'h0, ADDR_BRIDGE_CONTROL}, 32'h0);
		rd("io_window", {24'h0, ADDR_IO_WINDOW}, 32'h0000FFFF);
		rd("irq_status", {24'h0, ADDR_IRQ_STATUS}, 32'h0);
		rd("irq_mask", {24'h0, ADDR_IRQ_MASK}, 32'h0);
		ahb(1'b1, 32'h00000060, 32'hFFFFFFFF);
		rd("unmapped", 32'h00000060, 32'h0);
		ahb(1'b1, {24'h0, ADDR_ERROR_COMMAND}, 32'hFFFFFFFF);
		rd("error_command", {24'h0, ADDR_ERROR_COMMAND}, 32'h00000001);
		ahb(1'b1, {24'h0, ADDR_ERROR_COMMAND}, 32'h0);
	endtask
	task automatic test_routing;
		io(16'h0300, 1'b1);
		ahb(1'b1, {24'h0, ADDR_IO_WINDOW}, 32'h0FFF0100);
		io(16'h0300, 1'b0);
		ahb(1'b1, {24'h0, ADDR_BRIDGE_CONTROL}, 32'h00000004);
		io(16'h0300, 1'b1);
		io(16'h0700, 1'b1);
		io(16'h0400, 1'b0);
		io(16'h0100, 1'b1);
		io(16'h1000, 1'b1);
		check("forwarded", {24'h0, sec_count}, 32'h2);
	endtask
	task automatic test_errors;
		ahb(1'b1, {24'h0, ADDR_BRIDGE_CONTROL}, 32'h0);
		err('{parity: 1'b1, tabort: 1'b0, other: 1'b0}, 1'b0);
		ahb(1'b1, {24'h0, ADDR_BRIDGE_CONTROL}, 32'h00000101);
		err('{parity: 1'b1, tabort: 1'b0, other: 1'b0}, 1'b1);
		ahb(1'b1, {24'h0, ADDR_BRIDGE_CONTROL}, 32'h00000001);
		err('{parity: 1'b1, tabort: 1'b0, other: 1'b0}, 1'b0);
		ahb(1'b1, {24'h0, ADDR_BRIDGE_CONTROL}, 32'h00000100);
		err('{parity: 1'b1, tabort: 1'b0, other: 1'b0}, 1'b0);
		err('{parity: 1'b0, tabort: 1'b0, other: 1'b1}, 1'b1);
		ahb(1'b1, {24'h0, ADDR_BRIDGE_CONTROL}, 32'h00000102);
		err('{parity: 1'b0, tabort: 1'b0, other: 1'b1}, 1'b1);
		err('{parity: 1'b1, tabort: 1'b0, other: 1'b0}, 1'b0);
		err('{parity: 1'b0, tabort: 1'b1, other: 1'b0}, 1'b0);
		ahb(1'b1, {24'h0, ADDR_ERROR_COMMAND}, 32'h00000001);
		err('{parity: 1'b0, tabort: 1'b1, other: 1'b0}, 1'b1);
		err('{parity: 1'b1, tabort: 1'b1, other: 1'b1}, 1'b1);
	endtask
	task automatic test_irq;
		rd("irq_status", {24'h0, ADDR_IRQ_STATUS}, 32'h0000000F);
		check("irq", {31'h0, irq}, 32'h0);
		ahb(1'b1, {24'h0, ADDR_IRQ_MASK}, 32'h00000002);
		rd("irq_mask", {24'h0, ADDR_IRQ_MASK}, 32'h00000002);
		check("irq", {31'h0, irq}, 32'h1);
		ahb(1'b1, {24'h0, ADDR_IRQ_STATUS}, 32'h00000002);
		rd("irq_status", {24'h0, ADDR_IRQ_STATUS}, 32'h0000000D);
		check("irq", {31'h0, irq}, 32'h0);
	endtask
	task automatic test_midrun_reset;
		ahb(1'b1, {24'h0, ADDR_IRQ_MASK}, 32'h0000000F);
		@(posedge hclk);
		#1;
		check("irq", {31'h0, irq}, 32'h1);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		check("hreadyout", {31'h0, hreadyout}, 32'h1);
		check("hrdata", hrdata, 32'h0);
		check("io_route", {29'h0, io_route}, 32'h0);
		check("serr_cycle", {31'h0, serr_cycle}, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		rd("io_window", {24'h0, ADDR_IO_WINDOW}, 32'h0000FFFF);
		rd("irq_status", {24'h0, ADDR_IRQ_STATUS}, 32'h0);
		rd("irq_mask", {24'h0, ADDR_IRQ_MASK}, 32'h0);
		rd("bridge_control", {24'h0, ADDR_BRIDGE_CONTROL}, 32'h0);
	endtask

	task automatic print_verdict;
		$display("checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset();
		test_routing();
		test_errors();
		test_irq();
		test_midrun_reset();
		print_verdict();
	end
endmodule
